// file: pkg/mdsc_flag_if.sv
// condition flags passing between the register bank and its latch
`timescale 1ns/1ps
interface mdsc_flag_if;
  logic [mdsc_pkg::NFLAGS-1:0] raw;
  logic [mdsc_pkg::NFLAGS-1:0] flags;
  logic clear;
  modport latch (input raw, input clear, output flags);
  modport bank (output raw, output clear, input flags);
endinterface : mdsc_flag_if

// file: pkg/mdsc_pkg.sv
// constants and types shared by the motor driver status and control register bank
package mdsc_pkg;
  // register access port widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [4:0] OFS_FAULT_SUMMARY = 5'h00;
  localparam logic [4:0] OFS_DIAGNOSTIC_DETAIL = 5'h01;
  localparam logic [4:0] OFS_DRIVE_CONFIG_ONE = 5'h02;
  localparam logic [4:0] OFS_PROTECTION_CONFIG = 5'h03;
  localparam logic [4:0] OFS_OUTPUT_CONTROL = 5'h04;
  localparam logic [4:0] OFS_LOAD_CHECK_CONFIG = 5'h05;
  // values after reset
  localparam logic [7:0] RST_DRIVE_CONFIG_ONE = 8'h51;
  localparam logic [7:0] RST_PROTECTION_CONFIG = 8'h0C;
  localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h40;
  localparam logic [7:0] RST_LOAD_CHECK_CONFIG = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  // drive_config_one field positions
  localparam int OFF_TIME_HI = 7;
  localparam int OFF_TIME_LO = 6;
  localparam int INPUT_SRC_BIT = 5;
  localparam int SLEW_HI = 4;
  localparam int SLEW_LO = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  // protection_config field positions
  localparam int REG_REPORT_BIT = 7;
  localparam int OTW_REPORT_BIT = 5;
  localparam int PUMP_UV_DIS_BIT = 4;
  // output_control field positions and lock codes
  localparam int CLEAR_BIT = 7;
  localparam int LOCK_HI = 6;
  localparam int LOCK_LO = 4;
  localparam logic [2:0] LOCK_CODE = 3'h3;
  localparam logic [2:0] UNLOCK_CODE = 3'h4;
  // fault_summary bit positions
  localparam int FS_GLOBAL = 6;
  localparam int FS_OTW = 5;
  localparam int FS_SUPPLY_UNDERVOLTAGE = 4;
  localparam int FS_PUMP_UNDERVOLTAGE = 3;
  localparam int FS_OCP = 2;
  localparam int FS_TSD = 1;
  localparam int FS_OLD = 0;
  // condition vector positions
  localparam int NFLAGS = 12;
  localparam int FL_OTW = 0;
  localparam int FL_SUPPLY_UNDERVOLTAGE = 1;
  localparam int FL_PUMP_UNDERVOLTAGE = 2;
  localparam int FL_TSD = 3;
  localparam int FL_OL1 = 4;
  localparam int FL_OL2 = 5;
  localparam int FL_OCH1 = 6;
  localparam int FL_OCL1 = 7;
  localparam int FL_OCH2 = 8;
  localparam int FL_OCL2 = 9;
  localparam int FL_REG1 = 10;
  localparam int FL_REG2 = 11;
  // sticky conditions; current regulation stays live
  localparam logic [11:0] STICKY_MASK = 12'h3FF;
  localparam logic [11:0] FLAGS_RST = 12'h000;
  // bridge control modes
  typedef enum logic [1:0] {
    MDSC_PH_EN = 2'b00,
    MDSC_PWM = 2'b01,
    MDSC_HALF_BRIDGE = 2'b10,
    MDSC_HIZ = 2'b11
  } mdsc_mode_e;
endpackage : mdsc_pkg

// file: rtl/mdsc_fault_latch.sv
// synchronises raw condition inputs and holds the sticky ones until cleared
`timescale 1ns/1ps
module mdsc_fault_latch #(
  parameter int N = mdsc_pkg::NFLAGS,
  parameter logic [11:0] STICKY = mdsc_pkg::STICKY_MASK
) (
  input wire logic clk_sys,
  input wire logic resetn,
  mdsc_flag_if.latch fl
);
  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] held;
  logic [N-1:0] next_held;

  // the first stage feeds only the second, conditions come from analog logic
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= fl.raw;
      sync_b <= sync_a;
    end
  end

  // per bit: a new event wins over a clear arriving in the same cycle
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_comb begin
      if (STICKY[i]) begin
        next_held[i] = sync_b[i] | (held[i] & ~fl.clear); // RULE10
      end else begin
        next_held[i] = sync_b[i]; // RULE4
      end
    end
  end

  // flag register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      held <= mdsc_pkg::FLAGS_RST; // RULE11
    end else begin
      held <= next_held;
    end
  end

  assign fl.flags = held;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sticky_set_a: assert property (sync_b[mdsc_pkg::FL_TSD] |=> held[mdsc_pkg::FL_TSD]) // RULE10
    else $error("raised condition not latched");
  sticky_hold_a: assert property (held[mdsc_pkg::FL_OL1] && !fl.clear |=> held[mdsc_pkg::FL_OL1]) // RULE3
    else $error("latched flag lost without clear");
endmodule : mdsc_fault_latch

// file: rtl/mdsc_regs.sv
// status and control register bank of the h-bridge motor driver
//
// Functional notes
// RULE1 - host writes to the two status registers change nothing.
// RULE2 - fault_summary holds global fault in bit 6 as inverse of fault_pin_n, then warning and fault flags.
// RULE3 - diagnostic_detail bits 7 and 6 flag open load on half bridge one and two.
// RULE4 - diagnostic_detail bits 5 and 4 read 1 only while output one or two is in current regulation.
// RULE5 - diagnostic_detail bits 3 to 0 flag overcurrent per transistor, high then low side, bridge one first.
// RULE6 - the host modifies no address outside 0x00 to 0x05.
// RULE7 - the four configuration registers at 0x02 to 0x05 keep written values and read them back; 0x02 ignores writes while locked, 0x04 bit 7 reads 0.
// RULE8 - drive_config_one holds off time, input source, slew rate and bridge mode with their defaults.
// RULE9 - bridge mode selects phase/enable, pwm, independent half bridges or inputs off with bridge hi-z.
// RULE10 - writing 1 to clear_faults clears the fault flags and the bit falls back to 0 by itself.
// RULE11 - every status bit, reserved bit 7 included, reads 0 after reset until a condition is seen.
`timescale 1ns/1ps
module mdsc_regs (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic overtemp_warning,
  input wire logic supply_undervoltage,
  input wire logic pump_undervoltage,
  input wire logic thermal_shutdown,
  input wire logic open_load_bridge_one,
  input wire logic open_load_bridge_two,
  input wire logic overcurrent_high_one,
  input wire logic overcurrent_low_one,
  input wire logic overcurrent_high_two,
  input wire logic overcurrent_low_two,
  input wire logic regulating_out_one,
  input wire logic regulating_out_two,
  output logic fault_pin_n,
  output logic clear_faults,
  output logic [1:0] off_time_sel,
  output logic input_from_regs,
  output logic [2:0] slew_rate_sel,
  output mdsc_pkg::mdsc_mode_e bridge_mode,
  output logic bridge_hiz,
  output logic [7:0] protection_cfg,
  output logic [7:0] output_cfg,
  output logic [7:0] load_check_cfg
);
  mdsc_flag_if fl ();

  logic [7:0] drive_config_one;
  logic [7:0] protection_config;
  logic [7:0] output_control;
  logic [7:0] load_check_config;
  logic [7:0] next_drive_config_one;
  logic [7:0] next_protection_config;
  logic [7:0] next_output_control;
  logic [7:0] next_load_check_config;
  logic next_clear_faults;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic next_fault_pin_n;
  logic [7:0] fault_summary;
  logic [7:0] diagnostic_detail;
  logic overcurrent_flag;
  logic open_load_flag;
  logic fault_any;
  logic wr_hit;
  logic locked;
  logic [11:0] f;

  // gather raw conditions for the latch
  assign fl.raw = {regulating_out_two, regulating_out_one,
                   overcurrent_low_two, overcurrent_high_two,
                   overcurrent_low_one, overcurrent_high_one,
                   open_load_bridge_two, open_load_bridge_one,
                   thermal_shutdown, pump_undervoltage,
                   supply_undervoltage, overtemp_warning};
  assign fl.clear = clear_faults;
  assign f = fl.flags;

  mdsc_fault_latch u_latch (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .fl(fl)
  );

  // summary flags built from the per-transistor and per-bridge detail
  assign overcurrent_flag = |f[mdsc_pkg::FL_OCL2:mdsc_pkg::FL_OCH1];
  assign open_load_flag = f[mdsc_pkg::FL_OL1] | f[mdsc_pkg::FL_OL2];

  // warnings and regulation reach the fault pin only when reporting is on
  always_comb begin
    fault_any = f[mdsc_pkg::FL_SUPPLY_UNDERVOLTAGE] | f[mdsc_pkg::FL_TSD] | overcurrent_flag | open_load_flag;
    if (!protection_config[mdsc_pkg::PUMP_UV_DIS_BIT]) begin
      fault_any = fault_any | f[mdsc_pkg::FL_PUMP_UNDERVOLTAGE];
    end
    if (protection_config[mdsc_pkg::OTW_REPORT_BIT]) begin
      fault_any = fault_any | f[mdsc_pkg::FL_OTW];
    end
    if (protection_config[mdsc_pkg::REG_REPORT_BIT]) begin
      fault_any = fault_any | f[mdsc_pkg::FL_REG1] | f[mdsc_pkg::FL_REG2];
    end
    next_fault_pin_n = ~fault_any;
  end

  // status images; reserved bit 7 stays zero
  always_comb begin
    fault_summary = mdsc_pkg::RST_STATUS; // RULE11
    fault_summary[mdsc_pkg::FS_GLOBAL] = ~fault_pin_n; // RULE2
    fault_summary[mdsc_pkg::FS_OTW] = f[mdsc_pkg::FL_OTW]; // RULE2
    fault_summary[mdsc_pkg::FS_SUPPLY_UNDERVOLTAGE] = f[mdsc_pkg::FL_SUPPLY_UNDERVOLTAGE];
    fault_summary[mdsc_pkg::FS_PUMP_UNDERVOLTAGE] = f[mdsc_pkg::FL_PUMP_UNDERVOLTAGE];
    fault_summary[mdsc_pkg::FS_OCP] = overcurrent_flag;
    fault_summary[mdsc_pkg::FS_TSD] = f[mdsc_pkg::FL_TSD];
    fault_summary[mdsc_pkg::FS_OLD] = open_load_flag;
    diagnostic_detail = {f[mdsc_pkg::FL_OL1], f[mdsc_pkg::FL_OL2], // RULE3
                         f[mdsc_pkg::FL_REG1], f[mdsc_pkg::FL_REG2], // RULE4
                         f[mdsc_pkg::FL_OCH1], f[mdsc_pkg::FL_OCL1], // RULE5
                         f[mdsc_pkg::FL_OCH2], f[mdsc_pkg::FL_OCL2]};
  end

  // a lock code in output_control freezes drive_config_one
  assign locked = (output_control[mdsc_pkg::LOCK_HI:mdsc_pkg::LOCK_LO] == mdsc_pkg::LOCK_CODE);
  assign wr_hit = reg_req & reg_wr;

  // register writes; status offsets and unmapped offsets fall through untouched
  always_comb begin
    next_drive_config_one = drive_config_one;
    next_protection_config = protection_config;
    next_output_control = output_control;
    next_load_check_config = load_check_config;
    next_clear_faults = 1'b0;
    if (wr_hit) begin
      unique case (reg_addr)
        mdsc_pkg::OFS_DRIVE_CONFIG_ONE: begin
          if (!locked) begin
            next_drive_config_one = reg_wdata; // RULE7
          end
        end
        mdsc_pkg::OFS_PROTECTION_CONFIG: begin
          next_protection_config = reg_wdata; // RULE7
        end
        mdsc_pkg::OFS_OUTPUT_CONTROL: begin
          // clear bit is a strobe only, never stored
          next_output_control = reg_wdata;
          next_output_control[mdsc_pkg::CLEAR_BIT] = 1'b0; // RULE10
          next_clear_faults = reg_wdata[mdsc_pkg::CLEAR_BIT]; // RULE10
        end
        mdsc_pkg::OFS_LOAD_CHECK_CONFIG: begin
          next_load_check_config = reg_wdata; // RULE7
        end
        default: begin
          // status and reserved offsets ignore writes
          next_drive_config_one = drive_config_one; // RULE1
        end
      endcase
    end
  end

  // answer every access with the content held before the access
  always_comb begin
    next_reg_rvalid = reg_req;
    next_reg_rdata = reg_rdata;
    if (reg_req) begin
      unique case (reg_addr)
        mdsc_pkg::OFS_FAULT_SUMMARY: next_reg_rdata = fault_summary;
        mdsc_pkg::OFS_DIAGNOSTIC_DETAIL: next_reg_rdata = diagnostic_detail;
        mdsc_pkg::OFS_DRIVE_CONFIG_ONE: next_reg_rdata = drive_config_one;
        mdsc_pkg::OFS_PROTECTION_CONFIG: next_reg_rdata = protection_config;
        mdsc_pkg::OFS_OUTPUT_CONTROL: next_reg_rdata = output_control;
        mdsc_pkg::OFS_LOAD_CHECK_CONFIG: next_reg_rdata = load_check_config;
        default: next_reg_rdata = 8'h00; // RULE6
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_config_one <= mdsc_pkg::RST_DRIVE_CONFIG_ONE; // RULE8
      protection_config <= mdsc_pkg::RST_PROTECTION_CONFIG;
      output_control <= mdsc_pkg::RST_OUTPUT_CONTROL;
      load_check_config <= mdsc_pkg::RST_LOAD_CHECK_CONFIG;
      clear_faults <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      fault_pin_n <= 1'b1;
    end else begin
      drive_config_one <= next_drive_config_one;
      protection_config <= next_protection_config;
      output_control <= next_output_control;
      load_check_config <= next_load_check_config;
      clear_faults <= next_clear_faults;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
      fault_pin_n <= next_fault_pin_n;
    end
  end

  // decoded drive fields
  always_comb begin
    off_time_sel = drive_config_one[mdsc_pkg::OFF_TIME_HI:mdsc_pkg::OFF_TIME_LO]; // RULE8
    input_from_regs = drive_config_one[mdsc_pkg::INPUT_SRC_BIT];
    slew_rate_sel = drive_config_one[mdsc_pkg::SLEW_HI:mdsc_pkg::SLEW_LO];
    bridge_mode = mdsc_pkg::mdsc_mode_e'(drive_config_one[mdsc_pkg::MODE_HI:mdsc_pkg::MODE_LO]); // RULE9
    bridge_hiz = (bridge_mode == mdsc_pkg::MDSC_HIZ); // RULE9
    protection_cfg = protection_config;
    output_cfg = output_control;
    load_check_cfg = load_check_config;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // checks beside the logic
  ro_status_a: assert property (wr_hit && reg_addr <= mdsc_pkg::OFS_DIAGNOSTIC_DETAIL // RULE1
    |=> $stable(drive_config_one) && $stable(protection_config) && $stable(output_control)
        && $stable(load_check_config) && !clear_faults)
    else $error("status write disturbed state");
  global_fault_a: assert property (fault_summary[mdsc_pkg::FS_GLOBAL] == !fault_pin_n) // RULE2
    else $error("global fault bit not inverse of pin");
  supply_undervoltage_pin_a: assert property (f[mdsc_pkg::FL_SUPPLY_UNDERVOLTAGE] |=> !fault_pin_n) // RULE2
    else $error("undervoltage did not pull fault pin");
  open_load_a: assert property (open_load_flag == (diagnostic_detail[7] | diagnostic_detail[6])) // RULE3
    else $error("open load summary mismatch");
  regul_live_a: assert property (regulating_out_one [*3] |=> diagnostic_detail[5]) // RULE4
    else $error("regulation bit not live");
  ocp_map_a: assert property (fault_summary[mdsc_pkg::FS_OCP] == |diagnostic_detail[3:0]) // RULE5
    else $error("overcurrent summary mismatch");
  cfg_keep_a: assert property (wr_hit && reg_addr == mdsc_pkg::OFS_LOAD_CHECK_CONFIG // RULE7
    |=> load_check_config == $past(reg_wdata))
    else $error("written value not retained");
  read_back_a: assert property (reg_req && !reg_wr && reg_addr == mdsc_pkg::OFS_PROTECTION_CONFIG // RULE7
    |=> reg_rvalid && reg_rdata == $past(protection_config))
    else $error("readback mismatch");
  hiz_mode_a: assert property (bridge_hiz == (drive_config_one[1:0] == 2'b11)) // RULE9
    else $error("hi-z decode wrong");
  clear_pulse_a: assert property (wr_hit && reg_addr == mdsc_pkg::OFS_OUTPUT_CONTROL && reg_wdata[7] // RULE10
    |=> clear_faults && !output_control[7] ##1 !clear_faults)
    else $error("clear strobe not self clearing");
  rsvd_zero_a: assert property (fault_summary[7] == 1'b0) // RULE11
    else $error("reserved bit set");
  // the clear bit is a strobe, so it must never read back as 1
  clear_never_a: assert property (!output_control[mdsc_pkg::CLEAR_BIT]) // RULE10
    else $error("clear bit stored");
  clear_idle_a: assert property (!(wr_hit && reg_addr == mdsc_pkg::OFS_OUTPUT_CONTROL) // RULE10
    |=> !clear_faults)
    else $error("clear strobe without write");
  // port timing: one answer per request, data held between accesses
  valid_pulse_a: assert property (reg_req |=> reg_rvalid) // RULE7
    else $error("request not answered");
  valid_idle_a: assert property (!reg_req |=> !reg_rvalid) // RULE7
    else $error("answer without request");
  rdata_hold_a: assert property (!reg_req |=> $stable(reg_rdata)) // RULE7
    else $error("read data moved without access");
  // written configuration lands one edge later unless locked
  cfg_prot_a: assert property (wr_hit && reg_addr == mdsc_pkg::OFS_PROTECTION_CONFIG // RULE7
    |=> protection_config == $past(reg_wdata))
    else $error("protection setup not retained");
  cfg_drive_a: assert property (wr_hit && !locked && reg_addr == mdsc_pkg::OFS_DRIVE_CONFIG_ONE // RULE7
    |=> drive_config_one == $past(reg_wdata))
    else $error("drive setup not retained");
  lock_hold_a: assert property (wr_hit && locked && reg_addr == mdsc_pkg::OFS_DRIVE_CONFIG_ONE // RULE7
    |=> $stable(drive_config_one))
    else $error("locked drive setup changed");
  unmapped_rd_a: assert property (reg_req && !reg_wr && reg_addr > mdsc_pkg::OFS_LOAD_CHECK_CONFIG // RULE6
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // a condition held three edges has crossed both sync stages and the latch
  otw_path_a: assert property (overtemp_warning [*3] |=> fault_summary[mdsc_pkg::FS_OTW]) // RULE2
    else $error("warning not flagged");
  pump_undervoltage_path_a: assert property (pump_undervoltage [*3] |=> fault_summary[mdsc_pkg::FS_PUMP_UNDERVOLTAGE]) // RULE2
    else $error("pump undervoltage not flagged");
  supply_undervoltage_path_a: assert property (supply_undervoltage [*3] // RULE2
    |=> fault_summary[mdsc_pkg::FS_SUPPLY_UNDERVOLTAGE] ##1 !fault_pin_n)
    else $error("undervoltage path too slow");
  tsd_path_a: assert property (thermal_shutdown [*3] // RULE2
    |=> fault_summary[mdsc_pkg::FS_TSD] ##1 fault_summary[mdsc_pkg::FS_GLOBAL])
    else $error("shutdown path too slow");
  ol_one_a: assert property (open_load_bridge_one [*3] // RULE3
    |=> diagnostic_detail[7] && fault_summary[mdsc_pkg::FS_OLD])
    else $error("first open load not flagged");
  ol_two_a: assert property (open_load_bridge_two [*3] |=> diagnostic_detail[6]) // RULE3
    else $error("second open load not flagged");
  ocp_high_a: assert property (overcurrent_high_one [*3] // RULE5
    |=> diagnostic_detail[3] && fault_summary[mdsc_pkg::FS_OCP])
    else $error("high side overcurrent not flagged");
  ocp_low_a: assert property (overcurrent_low_two [*3] // RULE5
    |=> diagnostic_detail[0] && fault_summary[mdsc_pkg::FS_OCP])
    else $error("low side overcurrent not flagged");
  regul_two_a: assert property (regulating_out_two [*3] |=> diagnostic_detail[4]) // RULE4
    else $error("second regulation bit not live");
  regul_drop_a: assert property (!regulating_out_one [*3] // RULE4
    |=> !diagnostic_detail[5])
    else $error("regulation bit stuck");

  // main scenarios seen at least once
  read_cov_c: cover property (reg_req && !reg_wr && reg_addr == mdsc_pkg::OFS_FAULT_SUMMARY && !fault_pin_n);
  clear_cov_c: cover property (clear_faults ##2 fault_pin_n);
  lock_cov_c: cover property (locked && wr_hit && reg_addr == mdsc_pkg::OFS_DRIVE_CONFIG_ONE);
  regul_cov_c: cover property (diagnostic_detail[5] && !diagnostic_detail[4]);
  hiz_cov_c: cover property (bridge_hiz);
endmodule : mdsc_regs

// file: tb/mdsc_host_model.sv
// host model that issues accesses on the parallel register port
`timescale 1ns/1ps
module mdsc_host_model (
  input wire logic clk_sys,
  output logic reg_req,
  output logic reg_wr,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_req = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 5'h1F;
    reg_wdata = 8'hA5;
  end

  // one access; gap idles first so slow hosts are seen too
  task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] wdata, input int gap,
                        output logic [7:0] rdata, output logic ok);
    ok = 1'b0;
    rdata = 8'h00;
    // reserved places are never written by the host
    if (wr && addr > mdsc_pkg::OFS_LOAD_CHECK_CONFIG) begin
      return;
    end
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    reg_req = 1'b1;
    reg_wr = wr;
    reg_addr = addr;
    reg_wdata = wdata;
    @(posedge clk_sys);
    #1;
    ok = (reg_rvalid === 1'b1);
    rdata = reg_rdata;
    reg_req = 1'b0;
    // released lines show the inverse so a stale value is never mistaken for live data
    reg_wr = ~wr;
    reg_addr = ~addr;
    reg_wdata = ~wdata;
  endtask : access
endmodule : mdsc_host_model

// file: tb/mdsc_regs_tb_top.sv
// self-checking testbench of the status and control register bank
`timescale 1ns/1ps
module mdsc_regs_tb_top;
  localparam int TIMEOUT_CYCLES = 3000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic reg_req, reg_wr, reg_rvalid, fault_pin_n, clear_faults, input_from_regs, bridge_hiz, rd_ok;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, protection_cfg, output_cfg, load_check_cfg, rd_val;
  logic [1:0] off_time_sel;
  logic [2:0] slew_rate_sel;
  mdsc_pkg::mdsc_mode_e bridge_mode;
  logic [11:0] cond = 12'h000;
  int failures = 0;
  int samples_checked = 0;
  int cycle_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  mdsc_host_model i_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  mdsc_regs i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .overtemp_warning(cond[mdsc_pkg::FL_OTW]), .supply_undervoltage(cond[mdsc_pkg::FL_SUPPLY_UNDERVOLTAGE]),
    .pump_undervoltage(cond[mdsc_pkg::FL_PUMP_UNDERVOLTAGE]), .thermal_shutdown(cond[mdsc_pkg::FL_TSD]),
    .open_load_bridge_one(cond[mdsc_pkg::FL_OL1]), .open_load_bridge_two(cond[mdsc_pkg::FL_OL2]),
    .overcurrent_high_one(cond[mdsc_pkg::FL_OCH1]), .overcurrent_low_one(cond[mdsc_pkg::FL_OCL1]),
    .overcurrent_high_two(cond[mdsc_pkg::FL_OCH2]), .overcurrent_low_two(cond[mdsc_pkg::FL_OCL2]),
    .regulating_out_one(cond[mdsc_pkg::FL_REG1]), .regulating_out_two(cond[mdsc_pkg::FL_REG2]),
    .fault_pin_n(fault_pin_n), .clear_faults(clear_faults), .off_time_sel(off_time_sel),
    .input_from_regs(input_from_regs), .slew_rate_sel(slew_rate_sel), .bridge_mode(bridge_mode),
    .bridge_hiz(bridge_hiz), .protection_cfg(protection_cfg), .output_cfg(output_cfg),
    .load_check_cfg(load_check_cfg));

  // hang guard
  always @(posedge clk_sys) begin
    cycle_count++;
    if (cycle_count >= TIMEOUT_CYCLES) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd(input logic [4:0] addr, input logic [7:0] exp, input string what);
    i_host.access(1'b0, addr, 8'h00, 0, rd_val, rd_ok);
    check("read answered", 8'h01, {7'h00, rd_ok});
    check(what, exp, rd_val);
  endtask : rd

  // a write answers with the content held before it
  task automatic wr(input logic [4:0] addr, input logic [7:0] data, input logic [7:0] old, input string what);
    i_host.access(1'b1, addr, data, 1, rd_val, rd_ok);
    check(what, old, rd_val);
  endtask : wr

  // expected status bytes with the default reporting setup (warning and regulation kept off the pin)
  function automatic logic [7:0] exp_fault(input logic [11:0] c);
    logic oc, ol, pin;
    oc = c[mdsc_pkg::FL_OCH1] | c[mdsc_pkg::FL_OCL1] | c[mdsc_pkg::FL_OCH2] | c[mdsc_pkg::FL_OCL2];
    ol = c[mdsc_pkg::FL_OL1] | c[mdsc_pkg::FL_OL2];
    pin = oc | ol | c[mdsc_pkg::FL_SUPPLY_UNDERVOLTAGE] | c[mdsc_pkg::FL_PUMP_UNDERVOLTAGE] | c[mdsc_pkg::FL_TSD];
    return {1'b0, pin, c[mdsc_pkg::FL_OTW], c[mdsc_pkg::FL_SUPPLY_UNDERVOLTAGE], c[mdsc_pkg::FL_PUMP_UNDERVOLTAGE], oc, c[mdsc_pkg::FL_TSD], ol};
  endfunction : exp_fault

  function automatic logic [7:0] exp_diag(input logic [11:0] c);
    return {c[mdsc_pkg::FL_OL1], c[mdsc_pkg::FL_OL2], c[mdsc_pkg::FL_REG1], c[mdsc_pkg::FL_REG2],
            c[mdsc_pkg::FL_OCH1], c[mdsc_pkg::FL_OCL1], c[mdsc_pkg::FL_OCH2], c[mdsc_pkg::FL_OCL2]};
  endfunction : exp_diag

  task automatic clear_flags();
    i_host.access(1'b1, 5'h04, 8'hC0, 0, rd_val, rd_ok);
    check("clear pulse", 8'h01, {7'h00, clear_faults});
    repeat (3) @(posedge clk_sys);
    rd(5'h04, 8'h40, "clear bit self reset");
  endtask : clear_flags

  task automatic test_reset_values();
    logic [7:0] exp_tab [0:6];
    exp_tab = '{8'h00, 8'h00, 8'h51, 8'h0C, 8'h40, 8'h00, 8'h00};
    for (int a = 0; a < 7; a++) begin
      rd(a[4:0], exp_tab[a], "reset value");
    end
    check("idle fault pin", 8'h01, {7'h00, fault_pin_n});
    check("off time default", 8'h01, {6'h00, off_time_sel});
    check("input source default", 8'h00, {7'h00, input_from_regs});
    check("slew default", 8'h04, {5'h00, slew_rate_sel});
    check("mode default", 8'h01, {6'h00, bridge_mode});
  endtask : test_reset_values

  task automatic test_config_rw();
    logic [7:0] data, prev;
    wr(5'h03, 8'hA5, 8'h0C, "0x03 old value");
    wr(5'h05, 8'h5A, 8'h00, "0x05 old value");
    wr(5'h04, 8'h0F, 8'h40, "0x04 old value");
    rd(5'h03, 8'hA5, "0x03 readback");
    rd(5'h05, 8'h5A, "0x05 readback");
    rd(5'h04, 8'h0F, "0x04 readback");
    check("protection copy", 8'hA5, protection_cfg);
    check("load check copy", 8'h5A, load_check_cfg);
    check("output copy", 8'h0F, output_cfg);
    prev = 8'h51;
    // every bridge mode, with non-default fields around it
    for (int m = 0; m < 4; m++) begin
      data = {2'b10, 1'b1, 3'b011, m[1:0]};
      wr(5'h02, data, prev, "0x02 old value");
      check("bridge mode", {6'h00, m[1:0]}, {6'h00, bridge_mode});
      check("bridge hi-z", {7'h00, m == 3}, {7'h00, bridge_hiz});
      check("off time", 8'h02, {6'h00, off_time_sel});
      check("slew", 8'h03, {5'h00, slew_rate_sel});
      check("input source", 8'h01, {7'h00, input_from_regs});
      prev = data;
    end
    // lock code freezes drive_config_one until the unlock code is written
    wr(5'h04, 8'h30, 8'h0F, "0x04 lock");
    wr(5'h02, 8'h51, prev, "0x02 locked old value");
    rd(5'h02, prev, "0x02 kept while locked");
    wr(5'h04, 8'h40, 8'h30, "0x04 restore");
    wr(5'h02, 8'h51, prev, "0x02 restore");
    rd(5'h02, 8'h51, "0x02 after unlock");
    wr(5'h03, 8'h0C, 8'hA5, "0x03 restore");
  endtask : test_config_rw

  task automatic test_status_ro();
    @(posedge clk_sys);
    #1 cond[mdsc_pkg::FL_TSD] = 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(5'h00, 8'hFF, 8'h42, "0x00 before write");
    wr(5'h01, 8'hFF, 8'h00, "0x01 before write");
    rd(5'h00, 8'h42, "0x00 after write");
    rd(5'h01, 8'h00, "0x01 after write");
    @(posedge clk_sys);
    #1 cond = 12'h000;
    repeat (4) @(posedge clk_sys);
    clear_flags();
  endtask : test_status_ro

  // each condition alone: report, hold or drop, then clear
  task automatic test_fault_flags();
    logic [7:0] fs, dg;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      #1 cond = 12'h001 << i;
      repeat (5) @(posedge clk_sys);
      fs = exp_fault(cond);
      dg = exp_diag(cond);
      rd(5'h00, fs, "fault summary");
      rd(5'h01, dg, "diagnostic detail");
      check("fault pin", {7'h00, ~fs[6]}, {7'h00, fault_pin_n});
      @(posedge clk_sys);
      #1 cond = 12'h000;
      repeat (5) @(posedge clk_sys);
      // regulation is a live level, the others hold until cleared
      if (i >= 10) begin
        dg = 8'h00;
      end
      rd(5'h01, dg, "diagnostic after removal");
      clear_flags();
      repeat (4) @(posedge clk_sys);
      rd(5'h00, 8'h00, "fault summary cleared");
      rd(5'h01, 8'h00, "diagnostic cleared");
    end
  endtask : test_fault_flags

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1'b1;
    test_reset_values();
    test_config_rw();
    test_status_ro();
    test_fault_flags();
    print_verdict();
  end
endmodule : mdsc_regs_tb_top
